// ===== tmr8_top.sv
// Functional notes
// - while sync hold is set, written prescaler reset bits stay asserted
// - writing sync hold to zero clears both prescaler reset bits together
// - bits 6:1 of the sync control register read as zero
// - sync prescaler reset bit resets prescaler, self-clears unless hold set
// - sync prescaler reset reaches every timer sharing the prescaler
// - counter and both compare registers are 8 bits wide
// - overflow and compare flags in flag register, each with a mask bit
// - 3-bit clock select picks tick source; zero stops the counter
// - counter always accessible; cpu write beats clear or count
// - each tick clears, increments or decrements counter per mode
// - waveform mode is two bits in control A plus one in control B
// - bottom at 0x00 and max at 0xff are flagged to waveform logic
// - top is 0xff or compare A value depending on mode
// - compare always; match sets flag on next tick, raises request if masked in
// - compare flags clear on service acknowledge or write of one
// - matches drive waveform generator per mode and output mode fields
// - compare registers double-buffered in pwm modes only
// - buffered value moves to active compare only at top or bottom
// - cpu reaches buffer when buffering, active register otherwise
// - select 1 is undivided clock, 2..5 are taps /8 /64 /256 /1024
// - external pin synchronised; select 7 rising, 6 falling edges
// - normal mode sets overflow in the tick the counter wraps to zero
// - cpu counter write blocks the compare match of the next tick
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none

module tmr8_top
    import tmr8_pkg::*;
(
    input  wire logic                    I_CLOCK,                  // 25 MHz system clock
    input  wire logic                    I_RST_N,                  // synchronous reset, active low
    input  wire tmr8_pkg::tmr8_apb_req_s I_APB,                    // apb request
    output var      tmr8_pkg::tmr8_apb_rsp_s O_APB,                // apb response
    input  wire logic                    I_EXT_COUNT_PIN,          // external count pin, async
    input  wire logic [2:0]              I_IRQ_ACK,                // service acknowledge per flag
    output logic    [2:0]                O_IRQ_REQ,                // flag and mask per source
    output logic                         O_COMPARE_OUT_A,          // waveform A level
    output logic                         O_COMPARE_OUT_A_OVR,      // waveform A owns the pin
    output logic                         O_COMPARE_OUT_B,          // waveform B level
    output logic                         O_COMPARE_OUT_B_OVR,      // waveform B owns the pin
    output logic                         O_SYNC_PRESCALER_RESET,   // shared prescaler reset
    output logic                         O_ASYNC_PRESCALER_RESET,  // async prescaler reset
    output logic                         O_COUNTER_BOTTOM,         // counter at bottom
    output logic                         O_COUNTER_MAX             // counter at max
);

    import tmr8_pkg::*;

    // ==========================================================
    // bus slave decode
    logic        setup_ph;
    logic        wr_en;
    logic        mapped;
    logic        addr_ok;
    logic [7:0]  wbyte;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;

    assign setup_ph = I_APB.psel & ~I_APB.penable;
    assign wbyte    = I_APB.pwdata[7:0];
    assign addr_ok  = (I_APB.paddr[1:0] == 2'b00) && (I_APB.paddr <= ADDR_SYNC);
    assign mapped   = addr_ok;
    // zero wait states: every access completes at its first access-phase edge
    assign wr_en    = I_APB.psel & I_APB.penable & I_APB.pwrite & mapped;

    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_flag;
    logic wr_mask;
    logic wr_sync;

    assign wr_ctrl_a = wr_en && (I_APB.paddr == ADDR_CTRL_A);
    assign wr_ctrl_b = wr_en && (I_APB.paddr == ADDR_CTRL_B);
    assign wr_count  = wr_en && (I_APB.paddr == ADDR_COUNT);
    assign wr_cmp_a  = wr_en && (I_APB.paddr == ADDR_CMP_A);
    assign wr_cmp_b  = wr_en && (I_APB.paddr == ADDR_CMP_B);
    assign wr_flag   = wr_en && (I_APB.paddr == ADDR_FLAG);
    assign wr_mask   = wr_en && (I_APB.paddr == ADDR_MASK);
    assign wr_sync   = wr_en && (I_APB.paddr == ADDR_SYNC);

    // ==========================================================
    // control registers
    logic [1:0] com_a_q;
    logic [1:0] com_b_q;
    logic [1:0] wgm_lo_q;
    logic       wgm_hi_q;
    logic [2:0] cs_q;
    logic [2:0] mask_q;
    logic [1:0] force_p;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            com_a_q  <= 2'h0;
            com_b_q  <= 2'h0;
            wgm_lo_q <= 2'h0;
        end else if (wr_ctrl_a) begin
            com_a_q  <= wbyte[CTRL_A_COM_A_LSB +: 2];
            com_b_q  <= wbyte[CTRL_A_COM_B_LSB +: 2];
            wgm_lo_q <= wbyte[1:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            wgm_hi_q <= 1'b0;
            cs_q     <= CS_STOP;
        end else if (wr_ctrl_b) begin
            wgm_hi_q <= wbyte[CTRL_B_WGM2];
            cs_q     <= wbyte[2:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            mask_q <= 3'h0;
        end else if (wr_mask) begin
            mask_q <= wbyte[2:0];
        end
    end

    // force strobes are write-only and act for one cycle
    assign force_p = wr_ctrl_b ? {wbyte[CTRL_B_FORCE_B], wbyte[CTRL_B_FORCE_A]} : 2'b00;

    // ==========================================================
    // mode decode
    tmr8_wave_e wave;
    logic       is_phase;
    logic       is_fast;
    logic       is_pwm;
    logic       top_from_a;

    assign wave       = tmr8_wave_e'({wgm_hi_q, wgm_lo_q});
    assign is_phase   = (wave == WAVE_PC_MAX) || (wave == WAVE_PC_CMPA);
    assign is_fast    = (wave == WAVE_FAST_MAX) || (wave == WAVE_FAST_CMPA);
    assign is_pwm     = is_phase | is_fast;
    assign top_from_a = (wave == WAVE_CTC) || (wave == WAVE_PC_CMPA)
                        || (wave == WAVE_FAST_CMPA);

    // ==========================================================
    // synchronisation control and shared prescaler
    logic                hold_q;
    logic                sync_rst_q;
    logic                async_rst_q;
    logic [PRESC_W-1:0]  presc_q;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            hold_q <= 1'b0;
        end else if (wr_sync) begin
            hold_q <= wbyte[SYNC_HOLD];
        end
    end

    // a written reset bit lasts one cycle unless hold keeps it; releasing hold
    // lets both fall on the same edge so sharing timers restart together
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            sync_rst_q  <= 1'b0;
            async_rst_q <= 1'b0;
        end else if (wr_sync) begin
            sync_rst_q  <= wbyte[SYNC_SYNC_RST];
            async_rst_q <= wbyte[SYNC_ASYNC_RST];
        end else if (!hold_q) begin
            sync_rst_q  <= 1'b0;
            async_rst_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            presc_q <= '0;
        end else if (sync_rst_q) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    assign O_SYNC_PRESCALER_RESET  = sync_rst_q;
    assign O_ASYNC_PRESCALER_RESET = async_rst_q;

    // ==========================================================
    // external count pin: two-stage synchroniser, then edge detect
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= I_EXT_COUNT_PIN;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // ==========================================================
    // tick selection
    logic tick;

    always_comb begin
        case (cs_q)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = &presc_q[TAP8_BITS-1:0];
            CS_DIV64:    tick = &presc_q[TAP64_BITS-1:0];
            CS_DIV256:   tick = &presc_q[TAP256_BITS-1:0];
            CS_DIV1024:  tick = &presc_q[TAP1024_BITS-1:0];
            CS_EXT_FALL: tick = ~ext_s2_q & ext_s3_q;
            CS_EXT_RISE: tick = ext_s2_q & ~ext_s3_q;
            default:     tick = 1'b0;
        endcase
        if (sync_rst_q && (cs_q != CS_EXT_FALL) && (cs_q != CS_EXT_RISE)) begin
            tick = 1'b0;
        end
    end

    // ==========================================================
    // compare registers, per channel
    logic [7:0] act_q [2];
    logic [7:0] buf_q [2];
    logic [1:0] wr_cmp;
    logic [7:0] cnt_q;
    logic       down_q;
    logic [7:0] top;
    logic       at_top;
    logic       reload;

    assign wr_cmp = {wr_cmp_b, wr_cmp_a};
    assign top    = top_from_a ? act_q[0] : CNT_MAX;
    assign at_top = (cnt_q == top);
    // fast pwm reloads as the count wraps to bottom, phase correct at the top
    assign reload = tick && at_top && (is_fast || (is_phase && !down_q));

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_cmp
            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_N) begin
                    buf_q[ch] <= RESET_BYTE;
                end else if (wr_cmp[ch]) begin
                    buf_q[ch] <= wbyte;
                end
            end

            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_N) begin
                    act_q[ch] <= RESET_BYTE;
                end else if (wr_cmp[ch] && !is_pwm) begin
                    act_q[ch] <= wbyte;
                end else if (is_pwm && reload) begin
                    act_q[ch] <= buf_q[ch];
                end
            end
        end
    endgenerate

    // ==========================================================
    // counter unit
    logic [7:0] cnt_d;
    logic       block_q;
    logic       ovf_evt;

    always_comb begin
        cnt_d = cnt_q;
        if (is_phase) begin
            if (top == CNT_BOTTOM) begin
                cnt_d = CNT_BOTTOM;
            end else if (!down_q) begin
                cnt_d = at_top ? cnt_q - 8'h01 : cnt_q + 8'h01;
            end else begin
                cnt_d = (cnt_q == CNT_BOTTOM) ? cnt_q + 8'h01 : cnt_q - 8'h01;
            end
        end else begin
            cnt_d = at_top ? CNT_BOTTOM : cnt_q + 8'h01;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cnt_q <= RESET_BYTE;
        end else if (wr_count) begin
            cnt_q <= wbyte;
        end else if (tick) begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            down_q <= 1'b0;
        end else if (!is_phase) begin
            down_q <= 1'b0;
        end else if (tick && !down_q && at_top && (top != CNT_BOTTOM)) begin
            down_q <= 1'b1;
        end else if (tick && down_q && (cnt_q == CNT_BOTTOM)) begin
            down_q <= 1'b0;
        end
    end

    // a counter write arms a block that the next tick consumes, so a stopped
    // timer still loses the match it would have seen on its first tick
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    assign O_COUNTER_BOTTOM = (cnt_q == CNT_BOTTOM);
    assign O_COUNTER_MAX    = (cnt_q == CNT_MAX);

    always_comb begin
        if (is_phase) begin
            ovf_evt = tick && down_q && (cnt_q == CNT_BOTTOM);
        end else if (is_fast) begin
            ovf_evt = tick && at_top;
        end else begin
            ovf_evt = tick && (cnt_q == CNT_MAX);
        end
    end

    // ==========================================================
    // compare match and waveform generator
    logic [1:0] match;
    logic [1:0] com [2];
    logic [1:0] oc_q;

    assign com[0] = com_a_q;
    assign com[1] = com_b_q;

    generate
        for (ch = 0; ch < 2; ch++) begin : g_wave
            // the value before the tick is compared, so the flag lands one tick late
            assign match[ch] = tick && (cnt_q == act_q[ch]) && !block_q;

            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_N) begin
                    oc_q[ch] <= 1'b0;
                end else if (!is_pwm) begin
                    if (match[ch] || force_p[ch]) begin
                        case (com[ch])
                            2'h1:    oc_q[ch] <= ~oc_q[ch];
                            2'h2:    oc_q[ch] <= 1'b0;
                            2'h3:    oc_q[ch] <= 1'b1;
                            default: oc_q[ch] <= oc_q[ch];
                        endcase
                    end
                end else if (is_fast && tick && at_top && com[ch][1]) begin
                    oc_q[ch] <= ~com[ch][0];
                end else if (match[ch]) begin
                    case (com[ch])
                        2'h1:    oc_q[ch] <= (ch == 0 && wgm_hi_q) ? ~oc_q[ch] : oc_q[ch];
                        2'h2:    oc_q[ch] <= is_phase ? down_q : 1'b0;
                        2'h3:    oc_q[ch] <= is_phase ? ~down_q : 1'b1;
                        default: oc_q[ch] <= oc_q[ch];
                    endcase
                end
            end
        end
    endgenerate

    assign O_COMPARE_OUT_A     = oc_q[0];
    assign O_COMPARE_OUT_B     = oc_q[1];
    assign O_COMPARE_OUT_A_OVR = (com_a_q != 2'h0);
    assign O_COMPARE_OUT_B_OVR = (com_b_q != 2'h0);

    // ==========================================================
    // flags: an event in the clearing cycle survives the clear
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    assign flag_set = {match[1], match[0], ovf_evt};
    assign flag_clr = I_IRQ_ACK | (wr_flag ? wbyte[2:0] : 3'h0);

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            flag_q <= 3'h0;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    assign O_IRQ_REQ = flag_q & mask_q;

    // ==========================================================
    // read data, captured in the setup phase
    always_comb begin
        rd_d = 32'h0;
        case (I_APB.paddr)
            ADDR_CTRL_A: rd_d[7:0] = {com_a_q, com_b_q, 2'b00, wgm_lo_q};
            ADDR_CTRL_B: rd_d[7:0] = {4'h0, wgm_hi_q, cs_q};
            ADDR_COUNT:  rd_d[7:0] = cnt_q;
            ADDR_CMP_A:  rd_d[7:0] = is_pwm ? buf_q[0] : act_q[0];
            ADDR_CMP_B:  rd_d[7:0] = is_pwm ? buf_q[1] : act_q[1];
            ADDR_FLAG:   rd_d[7:0] = {5'h0, flag_q};
            ADDR_MASK:   rd_d[7:0] = {5'h0, mask_q};
            ADDR_SYNC:   rd_d[7:0] = {hold_q, 6'h00, sync_rst_q};
            default:     rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            prdata_q <= 32'h0;
        end else if (setup_ph) begin
            prdata_q <= rd_d;
        end
    end

    // one driver for the whole response word
    assign O_APB = '{prdata: prdata_q, pready: 1'b1,
                     pslverr: I_APB.psel & I_APB.penable & ~mapped};

endmodule

`default_nettype wire

// ===== tmr8_pkg.sv
`default_nettype none

package tmr8_pkg;

    // ==========================================================
    // register map, byte addresses of aligned 32-bit words
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_COUNT   = 8'h08;
    localparam logic [7:0] ADDR_CMP_A   = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B   = 8'h10;
    localparam logic [7:0] ADDR_FLAG    = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h18;
    localparam logic [7:0] ADDR_SYNC    = 8'h1c;

    // ==========================================================
    // field positions
    localparam int CTRL_A_COM_A_LSB = 6;
    localparam int CTRL_A_COM_B_LSB = 4;
    localparam int CTRL_B_FORCE_A   = 7;
    localparam int CTRL_B_FORCE_B   = 6;
    localparam int CTRL_B_WGM2      = 3;
    localparam int FLAG_OVF         = 0;
    localparam int FLAG_CMP_A       = 1;
    localparam int FLAG_CMP_B       = 2;
    localparam int SYNC_HOLD        = 7;
    localparam int SYNC_ASYNC_RST   = 1;
    localparam int SYNC_SYNC_RST    = 0;

    // ==========================================================
    // reset values and counter extremes
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] CNT_BOTTOM   = 8'h00;
    localparam logic [7:0] CNT_MAX      = 8'hff;

    // ==========================================================
    // clock select codes and prescaler taps
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIV1      = 3'h1;
    localparam logic [2:0] CS_DIV8      = 3'h2;
    localparam logic [2:0] CS_DIV64     = 3'h3;
    localparam logic [2:0] CS_DIV256    = 3'h4;
    localparam logic [2:0] CS_DIV1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;
    localparam int PRESC_W              = 10;
    localparam int TAP8_BITS            = 3;
    localparam int TAP64_BITS           = 6;
    localparam int TAP256_BITS          = 8;
    localparam int TAP1024_BITS         = 10;

    // ==========================================================
    // waveform modes
    typedef enum logic [2:0] {
        WAVE_NORMAL   = 3'h0,
        WAVE_PC_MAX   = 3'h1,
        WAVE_CTC      = 3'h2,
        WAVE_FAST_MAX = 3'h3,
        WAVE_RSVD4    = 3'h4,
        WAVE_PC_CMPA  = 3'h5,
        WAVE_RSVD6    = 3'h6,
        WAVE_FAST_CMPA= 3'h7
    } tmr8_wave_e;

    // ==========================================================
    // apb carriers
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tmr8_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tmr8_apb_rsp_s;

endpackage

`default_nettype wire

// ===== tmr8_monitor.sv
`default_nettype none
module tmr8_monitor
    import tmr8_pkg::*;
(
    input wire logic                    I_CLOCK,                 // clock
    input wire logic                    I_RST_N,                 // reset
    input wire tmr8_pkg::tmr8_apb_req_s I_APB,                   // apb request
    input wire tmr8_pkg::tmr8_apb_rsp_s O_APB,                   // apb response
    input wire logic [2:0]              I_IRQ_ACK,               // acks
    input wire logic [2:0]              O_IRQ_REQ,               // requests
    input wire logic                    O_SYNC_PRESCALER_RESET,  // shared reset
    input wire logic                    O_ASYNC_PRESCALER_RESET, // async reset
    input wire logic                    O_COUNTER_BOTTOM,        // at bottom
    input wire logic                    O_COUNTER_MAX            // at max
);
    // ==========================================================
    // access decode
    logic acc;
    logic wr_sync;
    logic wr_cnt;
    assign acc     = I_APB.psel && I_APB.penable;
    assign wr_sync = acc && I_APB.pwrite && (I_APB.paddr == ADDR_SYNC);
    assign wr_cnt  = acc && I_APB.pwrite && (I_APB.paddr == ADDR_COUNT);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    // ==========================================================
    // properties
    property p_self_clr;
        wr_sync && I_APB.pwdata[0] && !I_APB.pwdata[7]
            |=> O_SYNC_PRESCALER_RESET ##1 !O_SYNC_PRESCALER_RESET;
    endproperty
    property p_hold_off;
        wr_sync && !I_APB.pwdata[7]
            |=> ##1 !O_SYNC_PRESCALER_RESET && !O_ASYNC_PRESCALER_RESET;
    endproperty
    // next write can land two edges later at the soonest
    property p_hold_keep;
        wr_sync && I_APB.pwdata[7] && (I_APB.pwdata[1:0] == 2'h3)
            |=> (O_SYNC_PRESCALER_RESET && O_ASYNC_PRESCALER_RESET) [*2];
    endproperty
    property p_rsv;
        acc && !I_APB.pwrite && (I_APB.paddr == ADDR_SYNC) |-> O_APB.prdata[6:1] == 6'h00;
    endproperty
    property p_width;
        acc && !I_APB.pwrite && !O_APB.pslverr |-> O_APB.prdata[31:8] == 24'h000000;
    endproperty
    property p_cnt_wr;
        wr_cnt |=> (O_COUNTER_BOTTOM == ($past(I_APB.pwdata[7:0]) == CNT_BOTTOM))
            && (O_COUNTER_MAX == ($past(I_APB.pwdata[7:0]) == CNT_MAX));
    endproperty
    property p_ack;
        I_IRQ_ACK[0] && !O_COUNTER_MAX |=> !O_IRQ_REQ[0];
    endproperty
    property p_halt;
        O_SYNC_PRESCALER_RESET && O_COUNTER_BOTTOM && !wr_cnt |=> O_COUNTER_BOTTOM;
    endproperty
    a_self_clr: assert property (p_self_clr) else $error("sync reset not one pulse");
    a_hold_off: assert property (p_hold_off) else $error("resets not cleared");
    a_hold_keep: assert property (p_hold_keep) else $error("held resets dropped");
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
    a_width: assert property (p_width) else $error("upper read bits nonzero");
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
    a_ack: assert property (p_ack) else $error("ack did not clear flag");
    a_halt: assert property (p_halt) else $error("counter moved in reset");
    c_hold: cover property (wr_sync && I_APB.pwdata[7]);
    c_cnt: cover property (wr_cnt);
    c_ack: cover property (I_IRQ_ACK[0]);
endmodule
bind tmr8_top tmr8_monitor u_mon (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_APB(I_APB),
    .O_APB(O_APB), .I_IRQ_ACK(I_IRQ_ACK), .O_IRQ_REQ(O_IRQ_REQ),
    .O_SYNC_PRESCALER_RESET(O_SYNC_PRESCALER_RESET),
    .O_ASYNC_PRESCALER_RESET(O_ASYNC_PRESCALER_RESET),
    .O_COUNTER_BOTTOM(O_COUNTER_BOTTOM), .O_COUNTER_MAX(O_COUNTER_MAX));
`default_nettype wire

// ===== test_tmr8_top.sv
`default_nettype none
module test_tmr8_top;
    import tmr8_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clock;
    logic          rst_n;
    tmr8_apb_req_s req;
    tmr8_apb_rsp_s rsp;
    logic          ext_pin;
    logic [2:0]    ack;
    logic [2:0]    irq;
    logic          sres;
    logic          ares;
    logic          bot;
    logic          mx;
    logic          oa;
    logic          oa_ovr;
    logic [31:0]   r;
    logic          e;
    int            err_count;
    int            total_checks;
    int            cycles;
    int            div [4] = '{8, 64, 256, 1024};
    tmr8_top uut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_APB(req), .O_APB(rsp),
        .I_EXT_COUNT_PIN(ext_pin), .I_IRQ_ACK(ack), .O_IRQ_REQ(irq),
        .O_COMPARE_OUT_A(oa), .O_COMPARE_OUT_A_OVR(oa_ovr), .O_COMPARE_OUT_B(),
        .O_COMPARE_OUT_B_OVR(), .O_SYNC_PRESCALER_RESET(sres),
        .O_ASYNC_PRESCALER_RESET(ares), .O_COUNTER_BOTTOM(bot), .O_COUNTER_MAX(mx));
    // ==========================================================
    // clock and hang guard
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            print_verdict();
        end
    end
    // ==========================================================
    // tasks
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // prescaler phase at start and stop is only known to within one tick
    task automatic chk_near(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp && got !== exp + 8'h01 && got !== exp - 8'h01) begin
            err_count++;
            $display("[FAIL] %0t count %h near %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd_q, output logic err);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= {24'h000000, d};
        @(posedge clock);
        req.penable <= 1'b1;
        @(posedge clock);
        while (rsp.pready !== 1'b1) @(posedge clock);
        rd_q = rsp.prdata;
        err  = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 8'h00, r, e);
    endtask
    task automatic pulses();
        repeat (5) begin
            ext_pin <= 1'b1;
            tick(4);
            ext_pin <= 1'b0;
            tick(4);
        end
        tick(6);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        req = '0;
        ext_pin = 1'b0;
        ack = 3'h0;
        cycles = 0;
        err_count = 0;
        total_checks = 0;
        tick(6);
        rst_n <= 1'b1;
        tick(1);
        rd(ADDR_SYNC); chk(r, 32'h0);
        rd(ADDR_COUNT); chk(r, 32'h0);
        apb(1'b0, 8'h20, 8'h00, r, e); chk(r, 32'h0); chk(e, 32'h1);
        wr(ADDR_SYNC, 8'h83);
        rd(ADDR_SYNC); chk(r, 32'h81);
        chk({sres, ares}, 32'h3);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        tick(10);
        rd(ADDR_COUNT); chk(r, 32'h0);
        wr(ADDR_SYNC, 8'h00);
        tick(1);
        chk({sres, ares}, 32'h0);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_COUNT, 8'h55);
        tick(20);
        rd(ADDR_COUNT); chk(r, 32'h55);
        wr(ADDR_SYNC, 8'h01);
        rd(ADDR_SYNC); chk(r, 32'h0);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_COUNT, 8'hf0);
        wr(ADDR_CTRL_B, 8'h01);
        tick(30);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_FLAG); chk(r, 32'h7);
        chk(irq, 32'h1);
        ack <= 3'h1;
        tick(1);
        ack <= 3'h0;
        tick(1);
        chk(irq, 32'h0);
        rd(ADDR_FLAG); chk(r, 32'h6);
        wr(ADDR_FLAG, 8'h06);
        rd(ADDR_FLAG); chk(r, 32'h0);
        wr(ADDR_CMP_A, 8'h20);
        wr(ADDR_COUNT, 8'h20);
        wr(ADDR_CTRL_B, 8'h01);
        tick(5);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_FLAG); chk(r, 32'h0);
        wr(ADDR_COUNT, 8'h10);
        wr(ADDR_CTRL_B, 8'h01);
        tick(30);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_FLAG); chk(r, 32'h2);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_B, 8'h00);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_SYNC, 8'h81);
            wr(ADDR_CTRL_B, 8'(CS_DIV8) + 8'(i));
            wr(ADDR_SYNC, 8'h00);
            tick(8 * div[i]);
            wr(ADDR_CTRL_B, 8'h00);
            rd(ADDR_COUNT); chk_near(r[7:0], 8'h08);
        end
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
        pulses();
        wr(ADDR_CTRL_B, {5'h00, CS_EXT_FALL});
        pulses();
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_COUNT); chk(r, 32'ha);
        wr(ADDR_CTRL_A, 8'h42);
        chk({oa, oa_ovr}, 32'h1);
        wr(ADDR_CTRL_B, 8'h80);
        chk(oa, 32'h1);
        wr(ADDR_CMP_A, 8'h02);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_B, 8'h01);
        tick(2);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_COUNT); chk(r, 32'h2);
        chk(oa, 32'h0);
        wr(ADDR_CTRL_A, 8'h03);
        wr(ADDR_CMP_A, 8'h10);
        rd(ADDR_CMP_A); chk(r, 32'h10);
        wr(ADDR_CTRL_A, 8'h00);
        rd(ADDR_CMP_A); chk(r, 32'h2);
        wr(ADDR_COUNT, 8'hff);
        chk({bot, mx}, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
